//--- logic/wsp_regs.sv
// wake-up source flags, wake enables, ms prescaler and low-freq divider status registers
`timescale 1ns/1ps
`include "wsp_defines.svh"
module wsp_regs
	import wsp_pkg::*;
#(
	parameter int FAST_PER_SLOW = `WSP_FAST_PER_SLOW
)
(
	input  wire logic        i_ref_clk,
	input  wire logic        i_nrst,
	input  wire logic        i_reg_req,
	input  wire logic        i_reg_write,
	input  wire logic        i_reg_word,
	input  wire logic [15:0] i_reg_addr,
	input  wire logic [15:0] i_reg_wdata,
	output wire logic        o_reg_ack,
	output wire logic        o_reg_err,
	output wire logic [15:0] o_reg_rdata,
	input  wire logic [7:0]  i_wake_src,
	input  wire logic        i_low_power,
	input  wire logic        i_lf_sync_pulse,
	input  wire logic [12:0] i_lf_divider_calc,
	input  wire logic        i_lf_mode_change,
	output wire logic [7:0]  o_wake_enables,
	output wire logic        o_lifetime_wake_enable,
	output wire logic        o_wake_request,
	output wire logic        o_lf_resync,
	output wire logic [15:0] o_ms_divider_value,
	output wire logic        o_fast_tick,
	output wire logic        o_slow_tick
);

	wsp_byte_t   wake_flags;
	wsp_byte_t   wake_en;
	logic        wake_lifetime_overflow_enable;
	logic [15:0] ms_divider_value;
	logic        divider_sync_done;
	logic [12:0] lowfreq_divider_now;
	logic        ack_q;
	wsp_rsp_t    rsp_q;
	logic [15:0] rdata_q;
	logic        wake_req_q;
	logic        resync_q;
	logic        synced_once;
	logic [7:0]  src_s1;
	logic [7:0]  src_s2;
	logic [7:0]  src_s3;
	logic [7:0]  src_lvl;
	logic [7:0]  src_rise;

	// named views of the flag byte
	wire logic wake_amphour_hit_flag = wake_flags[`WSP_BIT_AMPHOUR];
	wire logic wake_pin0_flag        = wake_flags[`WSP_BIT_PIN0];

	// sources are asynchronous levels: three stages, a change counts once stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++)
		begin : g_src
			always_ff @(posedge i_ref_clk or negedge i_nrst)
			begin
				if (!i_nrst)
				begin
					src_s1[gi]  <= 1'b0;
					src_s2[gi]  <= 1'b0;
					src_s3[gi]  <= 1'b0;
					src_lvl[gi] <= 1'b0;
				end
				else
				begin
					src_s1[gi] <= i_wake_src[gi];
					src_s2[gi] <= src_s1[gi];
					src_s3[gi] <= src_s2[gi];
					if (src_s2[gi] == src_s3[gi])
						src_lvl[gi] <= src_s3[gi];
				end
			end
			assign src_rise[gi] = (src_s2[gi] == src_s3[gi]) & src_s3[gi] & ~src_lvl[gi];
		end
	endgenerate

	// address decode, both pages alias the same registers
	wire logic       page_hit = ((i_reg_addr & `WSP_PAGE_MASK) == `WSP_BASE_BLK)
		| ((i_reg_addr & `WSP_PAGE_MASK) == `WSP_BASE_NBLK);
	wire logic [3:0] off      = i_reg_addr[3:0];
	wire logic [3:0] off_even = {off[3:1], 1'b0};
	wire logic [3:0] off_odd  = {off[3:1], 1'b1};
	wire logic       acc      = i_reg_req & page_hit;
	// byte access to the prescaler and misaligned word access are refused
	wire logic       bad      = acc & ((~i_reg_word & (off_even == `WSP_OFF_PRESC))
		| (i_reg_word & off[0]));
	wire logic       wr_ok    = acc & i_reg_write & ~bad;
	wire logic       rd_ok    = acc & ~i_reg_write & ~bad;

	wire logic wr_stat   = wr_ok & (off_even == `WSP_OFF_STATUS_HI) & (i_reg_word | off[0]);
	wire logic wr_presc  = wr_ok & (off_even == `WSP_OFF_PRESC) & i_reg_word;
	wire logic wr_en_hi  = wr_ok & (off_even == `WSP_OFF_EN_HI) & (i_reg_word | ~off[0]);
	wire logic wr_en_lo  = wr_ok & (off_even == `WSP_OFF_EN_HI) & (i_reg_word | off[0]);
	// big-endian pairing: even offset is the high byte of a word
	wire wsp_byte_t wd_lo = i_reg_wdata[7:0];
	wire wsp_byte_t wd_hi = i_reg_word ? i_reg_wdata[15:8] : i_reg_wdata[7:0];

	// flag set needs the enable and low power; set beats a same-cycle clear
	wire wsp_byte_t flag_set  = src_rise & wake_en & {8{i_low_power}};
	wire wsp_byte_t flag_clr  = wr_stat ? wd_lo : 8'h00;
	wire wsp_byte_t next_flags = (wake_flags & ~flag_clr) | flag_set;

	// ready drops on a prescaler or mode change, sync pulse wins
	wire logic next_ready = i_lf_sync_pulse
		| (divider_sync_done & ~wr_presc & ~i_lf_mode_change);

	function automatic wsp_byte_t byte_at(input logic [3:0] o);
		case (o)
			`WSP_OFF_STATUS:   byte_at = wake_flags;
			`WSP_OFF_PRESC:    byte_at = ms_divider_value[15:8];
			`WSP_OFF_PRESC_LO: byte_at = ms_divider_value[7:0];
			`WSP_OFF_EN_HI:    byte_at = wake_en;
			`WSP_OFF_EN_LO:    byte_at = {wake_lifetime_overflow_enable, 7'h00};
			`WSP_OFF_TRIM_HI:  byte_at = {divider_sync_done, 2'b00, lowfreq_divider_now[12:8]};
			`WSP_OFF_TRIM_LO:  byte_at = lowfreq_divider_now[7:0];
			default:           byte_at = 8'h00;
		endcase
	endfunction

	wire logic [15:0] next_rdata = !rd_ok ? 16'h0000
		: (i_reg_word ? {byte_at(off_even), byte_at(off_odd)} : {8'h00, byte_at(off)});

	always_ff @(posedge i_ref_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			wake_flags                    <= `WSP_FLAGS_RESET;
			wake_en                       <= `WSP_EN_RESET;
			wake_lifetime_overflow_enable <= 1'b0;
			ms_divider_value              <= `WSP_PRESC_RESET;
			divider_sync_done             <= 1'b0;
			lowfreq_divider_now           <= `WSP_LF_RESET;
			synced_once                   <= 1'b0;
			ack_q                         <= 1'b0;
			rsp_q                         <= WSP_RSP_OK;
			rdata_q                       <= 16'h0000;
			wake_req_q                    <= 1'b0;
			resync_q                      <= 1'b0;
		end
		else
		begin
			wake_flags        <= next_flags;
			divider_sync_done <= next_ready;
			ack_q             <= acc;
			rsp_q             <= bad ? WSP_RSP_ERR : WSP_RSP_OK;
			rdata_q           <= next_rdata;
			wake_req_q        <= |flag_set;
			resync_q          <= wr_presc | i_lf_mode_change;
			if (wr_en_hi)
				wake_en <= wd_hi;
			if (wr_en_lo)
				wake_lifetime_overflow_enable <= wd_lo[`WSP_BIT_LIFETIME];
			if (wr_presc)
				ms_divider_value <= i_reg_wdata;
			if (i_lf_sync_pulse)
			begin
				lowfreq_divider_now <= i_lf_divider_calc;
				synced_once         <= 1'b1;
			end
		end
	end

	wsp_tick_if tick_bus ();

	assign tick_bus.divide  = ms_divider_value;
	assign tick_bus.restart = wr_presc;

	wsp_tick_div #(
		.FAST_PER_SLOW (FAST_PER_SLOW)
	) u_div (
		.i_ref_clk (i_ref_clk),
		.i_nrst    (i_nrst),
		.bus       (tick_bus)
	);

	assign o_reg_ack              = ack_q;
	assign o_reg_err              = (rsp_q == WSP_RSP_ERR);
	assign o_reg_rdata            = rdata_q;
	assign o_wake_enables         = wake_en;
	assign o_lifetime_wake_enable = wake_lifetime_overflow_enable;
	assign o_wake_request         = wake_req_q;
	assign o_lf_resync            = resync_q;
	assign o_ms_divider_value     = ms_divider_value;
	assign o_fast_tick            = tick_bus.fast_tick;
	assign o_slow_tick            = tick_bus.slow_tick;

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_nrst);

	a_w1c_clears: assert property ((wr_stat && wd_lo[`WSP_BIT_PIN0] && !flag_set[`WSP_BIT_PIN0])
		|=> !wake_pin0_flag) else $error("written one did not clear flag");
	a_zero_keeps: assert property ((flag_clr == 8'h00 && flag_set == 8'h00) |=> $stable(wake_flags))
		else $error("flags changed without cause");
	a_amphour_set: assert property ((src_rise[`WSP_BIT_AMPHOUR] && wake_en[`WSP_BIT_AMPHOUR] && i_low_power)
		|=> wake_amphour_hit_flag) else $error("amp-hour wake flag missing");

	generate
		for (gi = 0; gi < 8; gi++)
		begin : g_chk
			a_src_sets: assert property ((src_rise[gi] && wake_en[gi] && i_low_power) |=> wake_flags[gi])
				else $error("wake flag not set by its source");
			a_gate_flag: assert property ($rose(wake_flags[gi]) |-> $past(wake_en[gi]) && $past(i_low_power))
				else $error("wake flag set while disabled");
		end
	endgenerate

	a_byte_presc: assert property ((acc && !i_reg_word && off_even == `WSP_OFF_PRESC)
		|=> o_reg_err && $stable(ms_divider_value)) else $error("byte access to prescaler taken");
	a_page_ack: assert property (acc |=> o_reg_ack) else $error("page access not answered");
	a_no_ack: assert property (!acc |=> !o_reg_ack) else $error("answer without request");
	a_enlo_read: assert property ((rd_ok && !i_reg_word && off == `WSP_OFF_EN_LO)
		|=> o_reg_rdata == {8'h00, o_lifetime_wake_enable, 7'h00}) else $error("low enable byte wrong");
	a_trim_read: assert property ((rd_ok && !i_reg_word && off == `WSP_OFF_TRIM_HI)
		|=> o_reg_rdata[7:5] == {$past(divider_sync_done), 2'b00}) else $error("trim high byte wrong");
	a_en_write: assert property ((wr_en_hi && i_reg_word) |=> o_wake_enables == $past(i_reg_wdata[15:8]))
		else $error("enable byte not written");
	a_ready_drop: assert property ((wr_presc && !i_lf_sync_pulse) |=> !divider_sync_done && o_lf_resync)
		else $error("ready held over prescaler change");
	a_lf_initial: assert property (!synced_once |-> lowfreq_divider_now == `WSP_LF_RESET && !divider_sync_done)
		else $error("divider value before first sync");

endmodule

//--- logic/wsp_defines.svh
// offsets, field positions, reset values and counts of the wake-up and prescaler registers
`ifndef WSP_DEFINES_SVH
`define WSP_DEFINES_SVH

// register page bases in the global address space
`define WSP_BASE_BLK      16'h0200
`define WSP_BASE_NBLK     16'h0300
`define WSP_PAGE_MASK     16'hfff0

// byte offsets within the page
`define WSP_OFF_STATUS_HI 4'h2
`define WSP_OFF_STATUS    4'h3
`define WSP_OFF_PRESC     4'h4
`define WSP_OFF_PRESC_LO  4'h5
`define WSP_OFF_EN_HI     4'h6
`define WSP_OFF_EN_LO     4'h7
`define WSP_OFF_TRIM_HI   4'he
`define WSP_OFF_TRIM_LO   4'hf

// wake source bit positions, shared by the flag and the enable byte; then the lifetime enable bit and the ready bit of the trim word
`define WSP_BIT_AMPHOUR   7
`define WSP_BIT_CURRENT   6
`define WSP_BIT_CALIB     5
`define WSP_BIT_BUS       4
`define WSP_BIT_PIN3      3
`define WSP_BIT_PIN2      2
`define WSP_BIT_PIN1      1
`define WSP_BIT_PIN0      0
`define WSP_BIT_LIFETIME  7
`define WSP_BIT_READY     15

// reset values
`define WSP_FLAGS_RESET   8'h00
`define WSP_EN_RESET      8'h00
`define WSP_PRESC_RESET   16'h7d00
`define WSP_LF_RESET      13'h0200

// fast ticks per slow tick
`define WSP_FAST_PER_SLOW 8

`endif

//--- logic/wsp_pkg.sv
// types shared by the wake-up and prescaler register block
package wsp_pkg;

	typedef logic [7:0] wsp_byte_t;

	typedef enum logic [0:0]
	{
		WSP_RSP_OK  = 1'b0,
		WSP_RSP_ERR = 1'b1
	} wsp_rsp_t;

endpackage

//--- logic/wsp_tick_if.sv
// carrier between the register block and the tick divider
`timescale 1ns/1ps
interface wsp_tick_if;
	logic [15:0] divide;
	logic        restart;
	logic        fast_tick;
	logic        slow_tick;

	modport ctrl
	(
		output divide,
		output restart,
		input  fast_tick,
		input  slow_tick
	);

	modport div
	(
		input  divide,
		input  restart,
		output fast_tick,
		output slow_tick
	);
endinterface

//--- logic/wsp_tick_div.sv
// divides the link clock by the ms prescaler into fast and slow tick enables
`timescale 1ns/1ps
`include "wsp_defines.svh"
module wsp_tick_div
	import wsp_pkg::*;
#(
	parameter int FAST_PER_SLOW = `WSP_FAST_PER_SLOW,
	parameter int SW            = (FAST_PER_SLOW > 1) ? $clog2(FAST_PER_SLOW) : 1
)
(
	input  wire logic i_ref_clk,
	input  wire logic i_nrst,
	wsp_tick_if.div   bus
);

	logic [15:0]   cnt;
	logic [SW-1:0] scnt;
	logic          fast_q;
	logic          slow_q;

	// a zero divide acts as one; >= keeps the counter safe when the divide shrinks
	wire logic [15:0] limit = (bus.divide == 16'h0000) ? 16'h0000 : bus.divide - 16'h0001;
	wire logic        wrap  = (cnt >= limit);
	wire logic        swrap = (scnt == SW'(FAST_PER_SLOW - 1));

	always_ff @(posedge i_ref_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			cnt    <= 16'h0000;
			scnt   <= '0;
			fast_q <= 1'b0;
			slow_q <= 1'b0;
		end
		else if (bus.restart)
		begin
			cnt    <= 16'h0000;
			scnt   <= '0;
			fast_q <= 1'b0;
			slow_q <= 1'b0;
		end
		else
		begin
			cnt    <= wrap ? 16'h0000 : cnt + 16'h0001;
			fast_q <= wrap;
			slow_q <= wrap & swrap;
			if (wrap)
				scnt <= swrap ? '0 : scnt + SW'(1);
		end
	end

	assign bus.fast_tick = fast_q;
	assign bus.slow_tick = slow_q;

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_nrst);

	a_fast_spacing: assert property ((bus.fast_tick && !bus.restart && bus.divide > 16'h0001
		&& $stable(bus.divide)) |=> !bus.fast_tick) else $error("fast ticks too close");
	a_slow_on_fast: assert property (bus.slow_tick |-> bus.fast_tick)
		else $error("slow tick without fast tick");

endmodule

//--- bench/wsp_mcu_model.sv
// microcontroller-side master for the register request port
`timescale 1ns/1ps
module wsp_mcu_model
(
	input  wire logic        i_ref_clk,
	input  wire logic        i_reg_ack,
	input  wire logic        i_reg_err,
	input  wire logic [15:0] i_reg_rdata,
	output logic             o_reg_req,
	output logic             o_reg_write,
	output logic             o_reg_word,
	output logic [15:0]      o_reg_addr,
	output logic [15:0]      o_reg_wdata
);
	initial
	begin
		o_reg_req   = 1'b0;
		o_reg_write = 1'b0;
		o_reg_word  = 1'b0;
		o_reg_addr  = 16'h0000;
		o_reg_wdata = 16'h0000;
	end

	// one-cycle request pulse; answer sampled once the ack edge has landed
	task automatic access(input logic wr, input logic wd, input logic [15:0] a, input logic [15:0] d,
		output logic [15:0] q, output logic e, output logic k);
		@(posedge i_ref_clk);
		o_reg_req   <= 1'b1;
		o_reg_write <= wr;
		o_reg_word  <= wd; // the prescaler is reached with word accesses only
		o_reg_addr  <= a;
		o_reg_wdata <= d;
		@(posedge i_ref_clk);
		o_reg_req   <= 1'b0;
		// released lines must not keep showing the last value
		o_reg_write <= ~wr;
		o_reg_word  <= ~wd;
		o_reg_addr  <= ~a;
		o_reg_wdata <= ~d;
		#1;
		k = i_reg_ack;
		e = i_reg_err;
		q = i_reg_rdata;
	endtask
endmodule

//--- bench/tb_top.sv
// testbench: register accesses, wake sources, prescaler ticks and low-freq sync
`timescale 1ns/1ps
module tb_top;
	localparam int FPS = 2;
	logic        clk  = 1'b0;
	logic        nrst = 1'b0;
	logic [7:0]  src  = 8'h00;
	logic        lp   = 1'b0;
	logic        sync = 1'b0;
	logic        mchg = 1'b0;
	logic [12:0] calc = 13'h0000;
	logic        req, wr, wd, ack, err;
	logic [15:0] addr, wdata, rdata, msdiv;
	logic [7:0]  wen;
	logic        ltw, wreq, resync, fast, slow;
	int          n_checks   = 0;
	int          n_mismatch = 0;
	int          n_wreq     = 0;
	int          n_resync   = 0;

	always #20 clk = ~clk;

	// one-cycle pulses, counted at the edge after they rise
	always @(posedge clk)
	begin
		if (wreq === 1'b1)
			n_wreq++;
		if (resync === 1'b1)
			n_resync++;
	end

	wsp_mcu_model mcu_u (.i_ref_clk(clk), .i_reg_ack(ack), .i_reg_err(err), .i_reg_rdata(rdata),
		.o_reg_req(req), .o_reg_write(wr), .o_reg_word(wd), .o_reg_addr(addr), .o_reg_wdata(wdata));

	wsp_regs #(.FAST_PER_SLOW(FPS)) dut_u (.i_ref_clk(clk), .i_nrst(nrst), .i_reg_req(req),
		.i_reg_write(wr), .i_reg_word(wd), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_ack(ack),
		.o_reg_err(err), .o_reg_rdata(rdata), .i_wake_src(src), .i_low_power(lp),
		.i_lf_sync_pulse(sync), .i_lf_divider_calc(calc), .i_lf_mode_change(mchg),
		.o_wake_enables(wen), .o_lifetime_wake_enable(ltw), .o_wake_request(wreq),
		.o_lf_resync(resync), .o_ms_divider_value(msdiv), .o_fast_tick(fast), .o_slow_tick(slow));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		n_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic op(input logic w, input logic b, input logic [15:0] a, input logic [15:0] d,
		input logic [15:0] eq, input logic ee, input logic ek);
		logic [15:0] q;
		logic        e;
		logic        k;
		mcu_u.access(w, b, a, d, q, e, k);
		chk({15'h0000, k}, {15'h0000, ek}, "ack");
		chk({15'h0000, e}, {15'h0000, ee}, "err");
		chk(q, eq, "rdata");
	endtask

	task automatic gap(input logic s, input int exp);
		int n;
		n = 0;
		while (((s ? slow : fast) !== 1'b1) && n < 100)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		n = 0;
		do
		begin
			@(posedge clk);
			#1;
			n++;
		end
		while (((s ? slow : fast) !== 1'b1) && n < 100);
		chk(n[15:0], exp[15:0], "tick gap");
	endtask

	task automatic pulse_lf(input logic m, input logic [12:0] v);
		@(posedge clk);
		sync <= ~m;
		mchg <= m;
		calc <= v;
		@(posedge clk);
		sync <= 1'b0;
		mchg <= 1'b0;
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// whole run is well under a thousand cycles
	initial
	begin
		#100000;
		n_mismatch++;
		close_out();
	end

	initial
	begin
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		op(1'b0, 1'b0, 16'h0203, 16'h0000, 16'h0000, 1'b0, 1'b1);
		op(1'b0, 1'b1, 16'h0204, 16'h0000, 16'h7d00, 1'b0, 1'b1);
		op(1'b0, 1'b0, 16'h0206, 16'h0000, 16'h0000, 1'b0, 1'b1);
		op(1'b0, 1'b0, 16'h0207, 16'h0000, 16'h0000, 1'b0, 1'b1);
		op(1'b0, 1'b0, 16'h020e, 16'h0000, 16'h0002, 1'b0, 1'b1);
		op(1'b0, 1'b0, 16'h030f, 16'h0000, 16'h0000, 1'b0, 1'b1);
		op(1'b0, 1'b0, 16'h0204, 16'h0000, 16'h0000, 1'b1, 1'b1);
		op(1'b1, 1'b1, 16'h0205, 16'h1234, 16'h0000, 1'b1, 1'b1);
		op(1'b0, 1'b0, 16'h0404, 16'h0000, 16'h0000, 1'b0, 1'b0);
		$display("test reset and decode done");
		op(1'b1, 1'b0, 16'h0307, 16'h00ff, 16'h0000, 1'b0, 1'b1);
		op(1'b0, 1'b0, 16'h0207, 16'h0000, 16'h0080, 1'b0, 1'b1);
		chk({15'h0000, ltw}, 16'h0001, "lifetime enable");
		op(1'b1, 1'b0, 16'h0206, 16'h00ff, 16'h0000, 1'b0, 1'b1);
		chk({8'h00, wen}, 16'h00ff, "enables");
		// not in low power: an enabled source must not latch
		@(posedge clk);
		src[0] <= 1'b1;
		repeat (8) @(posedge clk);
		op(1'b0, 1'b0, 16'h0203, 16'h0000, 16'h0000, 1'b0, 1'b1);
		@(posedge clk);
		src[0] <= 1'b0;
		lp     <= 1'b1;
		// the low level must pass the synchroniser, or the next rise is no event
		repeat (8) @(posedge clk);
		for (int i = 0; i < 8; i++)
		begin
			src[i] <= 1'b1;
			repeat (8) @(posedge clk);
			op(1'b0, 1'b0, 16'h0203, 16'h0000, 16'h0001 << i, 1'b0, 1'b1);
			op(1'b1, 1'b0, 16'h0303, 16'h0000, 16'h0000, 1'b0, 1'b1);
			op(1'b0, 1'b0, 16'h0203, 16'h0000, 16'h0001 << i, 1'b0, 1'b1);
			op(1'b1, 1'b0, 16'h0303, 16'h0001 << i, 16'h0000, 1'b0, 1'b1);
			@(posedge clk);
			src[i] <= 1'b0;
			op(1'b0, 1'b0, 16'h0203, 16'h0000, 16'h0000, 1'b0, 1'b1);
			repeat (4) @(posedge clk);
		end
		op(1'b1, 1'b0, 16'h0206, 16'h00fd, 16'h0000, 1'b0, 1'b1);
		@(posedge clk);
		src[1] <= 1'b1;
		repeat (8) @(posedge clk);
		op(1'b0, 1'b0, 16'h0203, 16'h0000, 16'h0000, 1'b0, 1'b1);
		@(posedge clk);
		src[1] <= 1'b0;
		chk(n_wreq[15:0], 16'h0008, "wake requests");
		$display("test wake sources done");
		pulse_lf(1'b0, 13'h1abc);
		op(1'b0, 1'b0, 16'h020e, 16'h0000, 16'h009a, 1'b0, 1'b1);
		op(1'b0, 1'b0, 16'h020f, 16'h0000, 16'h00bc, 1'b0, 1'b1);
		op(1'b1, 1'b0, 16'h020e, 16'h00ff, 16'h0000, 1'b0, 1'b1);
		op(1'b1, 1'b1, 16'h0204, 16'h0004, 16'h0000, 1'b0, 1'b1);
		op(1'b0, 1'b0, 16'h020e, 16'h0000, 16'h001a, 1'b0, 1'b1);
		op(1'b0, 1'b1, 16'h0304, 16'h0000, 16'h0004, 1'b0, 1'b1);
		chk(msdiv, 16'h0004, "divider value");
		gap(1'b0, 4);
		gap(1'b1, 4 * FPS);
		pulse_lf(1'b0, 13'h1abc);
		op(1'b0, 1'b0, 16'h020e, 16'h0000, 16'h009a, 1'b0, 1'b1);
		pulse_lf(1'b1, 13'h0000);
		op(1'b0, 1'b0, 16'h020e, 16'h0000, 16'h001a, 1'b0, 1'b1);
		chk(n_resync[15:0], 16'h0002, "resync pulses");
		$display("test prescaler and sync done");
		// reset in mid-run brings every register back to its reset value
		@(posedge clk);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		op(1'b0, 1'b1, 16'h0204, 16'h0000, 16'h7d00, 1'b0, 1'b1);
		op(1'b0, 1'b0, 16'h020e, 16'h0000, 16'h0002, 1'b0, 1'b1);
		op(1'b0, 1'b1, 16'h0206, 16'h0000, 16'h0000, 1'b0, 1'b1);
		op(1'b0, 1'b0, 16'h0203, 16'h0000, 16'h0000, 1'b0, 1'b1);
		$display("test mid-run reset done");
		close_out();
	end
endmodule
